// ===== shared/irq_flag_pkg.sv
// Constants and carrier types for the request flag logic of the interrupt
// controller.
// Assumes a 32-bit APB slave port and a 25 MHz system clock.
package irq_flag_pkg;

  // ************************************************************
  // Register map (byte addresses on the APB port).
  // ************************************************************
  localparam logic [11:0] OFF_CLR = 12'h088; // Flag clear, write only.
  localparam logic [11:0] OFF_MODE = 12'h08c; // Input mode control.
  localparam logic [11:0] OFF_STAT = 12'h090; // Sticky event status.
  localparam logic [11:0] OFF_MASK = 12'h094; // Event mask.
  localparam logic [11:0] OFF_FLAG = 12'h098; // Live request flags.

  // ************************************************************
  // Field positions and values.
  // ************************************************************
  localparam int MODE_LVL_BIT = 0; // 1: level mode on ext_irq_zero.
  localparam int MODE_FALL_BIT = 1; // 1: falling edge in edge mode.
  localparam int MODE_W = 2; // Implemented mode bits.
  localparam logic [5:0] CLR_EXT0 = 6'h0a; // Clear code for ext_irq_zero.
  localparam logic [5:0] CLR_RX_DEF = 6'h18; // Rx clear code, arbitrary.
  localparam logic [MODE_W-1:0] MODE_RST = 2'h0; // Edge, rising.

  // Status and mask layout: one bit per event.
  localparam int EV_EXT0 = 0; // ext_irq_zero flag raised.
  localparam int EV_RX = 1; // serial_rx_irq flag raised.
  localparam int EV_DFLT = 2; // Default vector was handed out.
  localparam int EV_W = 3;

  // ************************************************************
  // Vectors.
  // ************************************************************
  localparam logic [15:0] VEC_DEFAULT = 16'h0008; // Fallback vector.
  localparam logic [23:0] VEC_BASE = 24'hffff00; // Vector table base.
  localparam logic [15:0] VEC_EXT0_DEF = 16'h0028; // Arbitrary default.
  localparam logic [15:0] VEC_RX_DEF = 16'h0060; // Arbitrary default.

  // Answer given to the CPU at a vector fetch.
  typedef struct packed {
    logic [15:0] vector; // Vector number handed out.
    logic [23:0] addr; // Table address the CPU reads.
  } vec_answer_t;

  // Which source the CPU accepted.
  typedef enum logic [0:0] {
    SRC_EXT0 = 1'b0,
    SRC_RX = 1'b1
  } irq_src_t;

endpackage

// ===== rtl/irq_flag_ctrl.sv
// Request flag logic for ext_irq_zero and serial_rx_irq, with APB registers,
// a sticky event status and a level interrupt output.
// Assumes the CPU core, the serial receiver and the APB master share
// clock_i; the ext_irq_zero pin is asynchronous.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module irq_flag_ctrl #(
  parameter logic [5:0] RX_CLR_CODE = irq_flag_pkg::CLR_RX_DEF,
  parameter logic [15:0] VEC_EXT0 = irq_flag_pkg::VEC_EXT0_DEF,
  parameter logic [15:0] VEC_RX = irq_flag_pkg::VEC_RX_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // APB slave port.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Request sources.
  input wire logic ext_irq_zero_i,
  input wire logic rx_event_i,
  input wire logic rx_buf_read_i,
  // CPU core side.
  input wire logic accept_i,
  input wire logic vec_fetch_i,
  output logic irq_req_o,
  output irq_flag_pkg::vec_answer_t vec_o,
  output logic vec_valid_o,
  output logic irq_o
);
  import irq_flag_pkg::*;

  // ************************************************************
  // State.
  // ************************************************************
  logic [2:0] sync_q, sync_d; // Pin synchroniser, bit 0 first.
  logic pin_q, pin_d; // Filtered pin level.
  logic [MODE_W-1:0] mode_q, mode_d; // Input mode control.
  logic ext0_q, ext0_d; // ext_irq_zero request flip-flop.
  logic rx_q, rx_d; // serial_rx_irq request flip-flop.
  logic busy_q, busy_d; // Accepted, vector not yet fetched.
  irq_src_t src_q, src_d; // Source that was accepted.
  vec_answer_t vec_q, vec_d; // Vector answer register.
  logic vvld_q, vvld_d; // Vector answer valid pulse.
  logic [EV_W-1:0] stat_q, stat_d; // Sticky event status.
  logic [EV_W-1:0] mask_q, mask_d; // Event enables.
  logic [31:0] rdat_q, rdat_d; // Read data, captured in setup.
  logic rvld_q, rvld_d; // Read data ready for access phase.

  // ************************************************************
  // Helpers.
  // ************************************************************
  logic lvl_mode; // Level mode selected.
  logic ext0_flag; // Flag as the CPU sees it.
  logic edge_hit; // Selected edge seen in edge mode.
  logic wr_en; // APB write completes this cycle.
  logic setup; // APB setup cycle.
  logic mapped; // Address hits a register.
  logic to_level; // Mode write turns edge into level.
  logic clr_ext0; // Clear code for ext_irq_zero written.
  logic src_alive; // Accepted source still requesting.
  logic [EV_W-1:0] ev; // Events of this cycle.

  // Decodes an APB address against the register map.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == OFF_CLR) || (a == OFF_MODE) || (a == OFF_STAT) ||
                (a == OFF_MASK) || (a == OFF_FLAG);
  endfunction

  // In level mode the flip-flop is bypassed, so the pin is the flag.
  assign lvl_mode = mode_q[MODE_LVL_BIT];
  assign ext0_flag = lvl_mode ? pin_q : ext0_q;
  assign setup = psel_i && !penable_i;
  assign mapped = is_mapped(paddr_i);
  // Ready only once read data stand in their register.
  assign pready_o = ce_i && rvld_q;
  assign pslverr_o = pready_o && !mapped;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && mapped;
  assign prdata_o = rdat_q;
  assign irq_req_o = ext0_flag || rx_q;
  assign vec_o = vec_q;
  assign vec_valid_o = vvld_q;
  assign irq_o = |(stat_q & mask_q);

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  // All state moves only while ce_i is high; otherwise it holds, except the vector valid pulse, which clears.
  always_comb begin
    sync_d = sync_q;
    pin_d = pin_q;
    mode_d = mode_q;
    ext0_d = ext0_q;
    rx_d = rx_q;
    busy_d = busy_q;
    src_d = src_q;
    vec_d = vec_q;
    vvld_d = 1'b0;
    stat_d = stat_q;
    mask_d = mask_q;
    rdat_d = rdat_q;
    rvld_d = rvld_q;
    edge_hit = 1'b0;
    to_level = 1'b0;
    clr_ext0 = 1'b0;
    src_alive = 1'b0;
    ev = '0;
    if (ce_i) begin
      // Only the second and third stages are compared; a change counts
      // once they agree, which rejects a single-cycle glitch.
      sync_d = {sync_q[1:0], ext_irq_zero_i};
      if (sync_q[1] == sync_q[2]) begin
        pin_d = sync_q[2];
      end
      edge_hit = mode_q[MODE_FALL_BIT] ? (pin_q && !pin_d)
                                       : (!pin_q && pin_d);
      // Register writes.
      if (wr_en && paddr_i == OFF_MODE) begin
        mode_d = pwdata_i[MODE_W-1:0];
        to_level = pwdata_i[MODE_LVL_BIT] && !lvl_mode;
      end
      clr_ext0 = wr_en && paddr_i == OFF_CLR && pwdata_i[5:0] == CLR_EXT0;
      if (wr_en && paddr_i == OFF_MASK) begin
        mask_d = pwdata_i[EV_W-1:0];
      end
      // Vector fetch: a source that dropped meanwhile gets the default.
      src_alive = (src_q == SRC_EXT0) ? ext0_flag : rx_q;
      if (vec_fetch_i && busy_q) begin
        busy_d = 1'b0;
        vvld_d = 1'b1;
        if (!src_alive) begin
          vec_d.vector = VEC_DEFAULT;
          ev[EV_DFLT] = 1'b1;
        end else if (src_q == SRC_EXT0) begin
          vec_d.vector = VEC_EXT0;
        end else begin
          vec_d.vector = VEC_RX;
        end
        vec_d.addr = VEC_BASE | {8'h00, vec_d.vector};
      end else if (accept_i && !busy_q && irq_req_o) begin
        busy_d = 1'b1;
        src_d = ext0_flag ? SRC_EXT0 : SRC_RX;
      end
      // ext_irq_zero flip-flop. In level mode it tracks the pin so that
      // a flag raised there survives a return to edge mode.
      if (lvl_mode) begin
        ext0_d = pin_d;
      end else if (edge_hit) begin
        ext0_d = 1'b1;
        ev[EV_EXT0] = 1'b1;
      end else if (clr_ext0) begin
        ext0_d = 1'b0;
      end else if (vec_fetch_i && busy_q && src_q == SRC_EXT0) begin
        ext0_d = 1'b0;
      end
      if (to_level) begin
        ext0_d = 1'b0;
      end
      if (lvl_mode && pin_d && !pin_q) begin
        ev[EV_EXT0] = 1'b1;
      end
      // Rx flip-flop: the clear register has no path to it.
      if (rx_event_i) begin
        rx_d = 1'b1;
        ev[EV_RX] = 1'b1;
      end else if (rx_buf_read_i) begin
        rx_d = 1'b0;
      end
      // Sticky status: a new event wins over a write-one clear.
      if (wr_en && paddr_i == OFF_STAT) begin
        stat_d = stat_q & ~pwdata_i[EV_W-1:0];
      end
      stat_d = stat_d | ev;
      // Read data are captured in the setup cycle.
      if (setup) begin
        rvld_d = 1'b1;
        unique case (paddr_i)
          OFF_MODE: rdat_d = {{(32-MODE_W){1'b0}}, mode_q};
          OFF_STAT: rdat_d = {{(32-EV_W){1'b0}}, stat_q};
          OFF_MASK: rdat_d = {{(32-EV_W){1'b0}}, mask_q};
          OFF_FLAG: rdat_d = {30'h0, rx_q, ext0_flag};
          default: rdat_d = 32'h0000_0000;
        endcase
      end else if (psel_i && penable_i) begin
        rvld_d = 1'b0;
      end
    end
  end

  // ************************************************************
  // Registers.
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sync_q <= 3'h0;
      pin_q <= 1'b0;
      mode_q <= MODE_RST;
      ext0_q <= 1'b0;
      rx_q <= 1'b0;
      busy_q <= 1'b0;
      src_q <= SRC_EXT0;
      vec_q <= '0;
      vvld_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      rdat_q <= 32'h0000_0000;
      rvld_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      pin_q <= pin_d;
      mode_q <= mode_d;
      ext0_q <= ext0_d;
      rx_q <= rx_d;
      busy_q <= busy_d;
      src_q <= src_d;
      vec_q <= vec_d;
      vvld_q <= vvld_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdat_q <= rdat_d;
      rvld_q <= rvld_d;
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  // The fallback vector and its table address are fixed numbers.
  default_vector_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && vec_fetch_i && busy_q && !src_alive |=>
      vec_valid_o && vec_o.vector == 16'h0008 && vec_o.addr == 24'hffff08)
    else $error("default vector not given");
  // Watched at the request output, so a latch in the path would show.
  level_follow_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    lvl_mode && !rx_q |-> irq_req_o == pin_q)
    else $error("level flag does not follow pin");
  mode_clear_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && to_level |=> !ext0_q)
    else $error("flag kept on switch to level");
  flag_kept_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && lvl_mode && pin_d && wr_en && paddr_i == OFF_MODE &&
    !pwdata_i[MODE_LVL_BIT] ##1 !lvl_mode |-> ext0_flag)
    else $error("flag lost leaving level mode");
  rx_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    rx_q && !(ce_i && rx_buf_read_i) |=> rx_q)
    else $error("rx flag cleared without read");
  // The receive source's own clear code must have no path to its flag.
  rx_code_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && wr_en && paddr_i == OFF_CLR && pwdata_i[5:0] == RX_CLR_CODE &&
    rx_q && !rx_buf_read_i |=> rx_q)
    else $error("rx flag cleared by clear code");
  level_drop_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    lvl_mode && $fell(pin_q) |-> !irq_req_o || rx_q)
    else $error("level request not withdrawn");
  clear_code_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && clr_ext0 && !lvl_mode && !edge_hit |=> !ext0_q)
    else $error("clear code did not clear");
  // A switch to level mode in the next cycle also clears the flag.
  edge_set_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && !lvl_mode && edge_hit && !to_level |=> ext0_q ##1 ext0_q ||
    $past(clr_ext0) || $past(busy_q) || $past(to_level))
    else $error("edge flag not held");

endmodule // irq_flag_ctrl

// ===== verification/irq_cpu_model.sv
// Behavioural CPU core and ext_irq_zero pin source facing irq_flag_ctrl.
// Assumes one shared clock; the bench steers it via go_i, gap_i, pin_i.
`timescale 1ns/1ps
module irq_cpu_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  input wire logic go_i,
  input wire logic [3:0] gap_i,
  input wire logic irq_req_i,
  input wire logic vec_valid_i,
  input wire irq_flag_pkg::vec_answer_t vec_i,
  output logic ext_irq_zero_o,
  output logic accept_o,
  output logic vec_fetch_o,
  output logic done_o,
  output irq_flag_pkg::vec_answer_t vec_seen_o
);
  import irq_flag_pkg::*;
  // ************************************************************
  // Response sequencer.
  // ************************************************************
  logic [1:0] ph_q; // 0 idle, 1 gap, 2 wait vector, 3 finished.
  logic [3:0] cnt_q; // Cycles left before the vector fetch.
  logic hold_q; // High pin level held while a response runs.
  // A pin high at accept is kept high until the vector answer arrives.
  assign ext_irq_zero_o = pin_i | hold_q;
  // A long gap lets the bench clear a flag between accept and fetch.
  always_ff @(posedge clock_i) begin
    accept_o <= 1'b0;
    vec_fetch_o <= 1'b0;
    if (!rst_b_i) begin
      ph_q <= 2'h0;
      done_o <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      case (ph_q)
        2'h0: if (go_i && irq_req_i) begin
          accept_o <= 1'b1;
          cnt_q <= gap_i;
          hold_q <= ext_irq_zero_o;
          done_o <= 1'b0;
          ph_q <= 2'h1;
        end
        2'h1: if (cnt_q == 4'h0) begin
          vec_fetch_o <= 1'b1;
          ph_q <= 2'h2;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
        2'h2: if (vec_valid_i) begin
          vec_seen_o <= vec_i;
          done_o <= 1'b1;
          hold_q <= 1'b0;
          ph_q <= 2'h3;
        end
        default: if (!go_i) begin
          ph_q <= 2'h0;
        end
      endcase
    end
  end
endmodule // irq_cpu_model

// ===== verification/tb_irq_flag_ctrl.sv
// Self-checking bench for irq_flag_ctrl: APB tasks plus the CPU model.
// Assumes a 25 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
module tb_irq_flag_ctrl;
  import irq_flag_pkg::*;
  // ************************************************************
  // Signals.
  // ************************************************************
  logic clock_i = 1'b0, rst_b_i = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
  logic rx_ev = 1'b0, rx_rd = 1'b0, go = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, ext0, accept, fetch, irq_req, vvalid, irq;
  logic done, e;
  logic [3:0] gap = 4'h0;
  vec_answer_t vec, seen;
  int errors = 0, check_count = 0, cyc = 0;
  initial forever #20 clock_i = ~clock_i;
  irq_flag_ctrl i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_irq_zero_i(ext0),
    .rx_event_i(rx_ev), .rx_buf_read_i(rx_rd), .accept_i(accept),
    .vec_fetch_i(fetch), .irq_req_o(irq_req), .vec_o(vec),
    .vec_valid_o(vvalid), .irq_o(irq));
  irq_cpu_model i_cpu (.clock_i(clock_i), .rst_b_i(rst_b_i), .pin_i(pin),
    .go_i(go), .gap_i(gap), .irq_req_i(irq_req), .vec_valid_i(vvalid),
    .vec_i(vec), .ext_irq_zero_o(ext0), .accept_o(accept),
    .vec_fetch_o(fetch), .done_o(done), .vec_seen_o(seen));
  // ************************************************************
  // Tasks.
  // ************************************************************
  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer. The request stands until the rising edge at which
  // pready is sampled high; read data and pslverr are taken at that edge
  // and only then is the request released.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Outputs are looked at mid-cycle, then the bench returns to a rising
  // edge so that the next stimulus is again driven there.
  task automatic chk_irq(input logic exp);
    @(negedge clock_i);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge clock_i);
  endtask
  task automatic chk_req(input logic exp);
    @(negedge clock_i);
    chk({31'h0, irq_req}, {31'h0, exp});
    @(posedge clock_i);
  endtask
  task automatic respond(input logic [3:0] g, input logic clr);
    int n;
    n = 0;
    @(posedge clock_i);
    go <= 1'b1;
    gap <= g;
    while (accept !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    // A clear with interrupts enabled provokes the fallback vector.
    if (clr) apb(1'b1, OFF_CLR, 32'h0a);
    while (done !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 200) errors++;
    @(posedge clock_i);
    // Low go stands for interrupts disabled; all other clears and mask
    // changes of the bench happen only while it is low.
    go <= 1'b0;
    tick(2);
  endtask
  // Cut a hang short well above the few hundred cycles the run needs.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  // ************************************************************
  // Scenarios.
  // ************************************************************
  initial begin
    tick(5);
    rst_b_i <= 1'b1;
    rdc(OFF_MODE, {30'h0, MODE_RST});
    rdc(OFF_FLAG, 32'h0);
    apb(1'b0, 12'h0a0, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    pin <= 1'b1; tick(6); rdc(OFF_FLAG, 32'h1);
    chk_req(1'b1);
    pin <= 1'b0; tick(6); rdc(OFF_FLAG, 32'h1);
    apb(1'b1, OFF_CLR, 32'h0a); rdc(OFF_FLAG, 32'h0);
    chk_req(1'b0);
    // Falling mode: a rising pin must not raise the flag.
    apb(1'b1, OFF_MODE, 32'h2);
    pin <= 1'b1; tick(6); rdc(OFF_FLAG, 32'h0);
    pin <= 1'b0; tick(6); rdc(OFF_FLAG, 32'h1);
    apb(1'b1, OFF_MODE, 32'h1); rdc(OFF_FLAG, 32'h0);
    pin <= 1'b1; tick(6); rdc(OFF_FLAG, 32'h1);
    chk_req(1'b1);
    pin <= 1'b0; tick(6); rdc(OFF_FLAG, 32'h0);
    chk_req(1'b0);
    pin <= 1'b1; tick(6); apb(1'b1, OFF_MODE, 32'h0);
    pin <= 1'b0; tick(6); rdc(OFF_FLAG, 32'h1);
    apb(1'b1, OFF_CLR, 32'h0a); tick(1);
    rdc(OFF_FLAG, 32'h0);
    apb(1'b1, OFF_STAT, 32'h7);
    apb(1'b1, OFF_MASK, 32'h0);
    rx_ev <= 1'b1; tick(1); rx_ev <= 1'b0;
    rdc(OFF_FLAG, 32'h2); chk_irq(1'b0);
    apb(1'b1, OFF_CLR, {26'h0, CLR_RX_DEF});
    apb(1'b1, OFF_CLR, 32'h0a); rdc(OFF_FLAG, 32'h2);
    apb(1'b1, OFF_MASK, 32'h2); chk_irq(1'b1);
    respond(4'h0, 1'b0);
    chk({16'h0, seen.vector}, {16'h0, VEC_RX_DEF});
    rdc(OFF_FLAG, 32'h2);
    rx_rd <= 1'b1; tick(1); rx_rd <= 1'b0;
    rdc(OFF_FLAG, 32'h0); chk_irq(1'b1);
    apb(1'b1, OFF_STAT, 32'h2); chk_irq(1'b0);
    // Flag withdrawn between accept and fetch gives the fallback.
    pin <= 1'b1; tick(6); respond(4'hf, 1'b1);
    chk({16'h0, seen.vector}, {16'h0, VEC_DEFAULT});
    chk({8'h0, seen.addr}, 32'h00ff_ff08);
    apb(1'b0, OFF_STAT, 32'h0); chk({31'h0, r[EV_DFLT]}, 32'h1);
    pin <= 1'b0; tick(6); pin <= 1'b1; tick(6);
    respond(4'h0, 1'b0);
    chk({16'h0, seen.vector}, {16'h0, VEC_EXT0_DEF});
    rdc(OFF_FLAG, 32'h0);
    pin <= 1'b0; tick(6);
    // Clock enable low freezes the synchroniser, so the edge must wait
    // for it; a design that ran on would already show the flag.
    ce <= 1'b0; pin <= 1'b1; tick(8);
    ce <= 1'b1; rdc(OFF_FLAG, 32'h0);
    tick(6); rdc(OFF_FLAG, 32'h1);
    print_verdict();
  end
endmodule // tb_irq_flag_ctrl
